// >>> rtl/itas_regs.svh
// Purpose: constants for the target address select block
// Assumes: 125 MHz core clock
// Notes: times in their own units, counts derived from them
`ifndef ITAS_REGS_SVH
`define ITAS_REGS_SVH
`define ITAS_CLK_MHZ 125
`define ITAS_LATCH_DELAY_US 768
`define ITAS_LATCH_DELAY_CYC (`ITAS_LATCH_DELAY_US * `ITAS_CLK_MHZ)
`define ITAS_ADDR_BASE 7'h5C
`define ITAS_LIVE_BIT 0
`define ITAS_LATCHED_BIT 1
`define ITAS_GENERIC_ADDR 7'h5B
`define ITAS_CNT_W 17
`endif

// >>> rtl/itas_pkg.sv
// Purpose: types for the target address select block
// Assumes: nothing
// Notes: one-hot capture sequencer states
package itas_pkg;
  typedef enum logic [2:0] {
    ITAS_WAIT = 3'h1,
    ITAS_COUNT = 3'h2,
    ITAS_HOLD = 3'h4
  } itas_state_t;
endpackage : itas_pkg

// >>> rtl/itas_sync_if.sv
// Purpose: carries synchronised select levels between modules
// Assumes: single clock domain
// Notes: none
`timescale 1ns/10ps
interface itas_sync_if;
  logic live;
  logic latched;
  modport src (output live, output latched);
  modport dst (input live, input latched);
endinterface : itas_sync_if

// >>> rtl/itas_sync.sv
// Purpose: two-stage synchronisers for both select pins
// Assumes: pins asynchronous to clock
// Notes: first stage read only by second stage
`timescale 1ns/10ps
module itas_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // pins
  input wire logic [1:0] pins,
  // synchronised levels
  itas_sync_if.src sync
);
  logic [1:0] meta_reg;
  logic [1:0] stab_reg;
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[i] <= 1'b0;
          stab_reg[i] <= 1'b0;
        end else if (clk_en) begin
          meta_reg[i] <= pins[i];
          stab_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
  assign sync.live = stab_reg[0];
  assign sync.latched = stab_reg[1];
endmodule : itas_sync

// >>> rtl/itas_addr_select.sv
// Purpose: works out the I2C target address from two select pins
// Assumes: soft reset strobe comes from the I2C register logic on this clock
// Notes: latched pin captured once per reset or soft reset
//
// Overview of operation
// - address bit 0 follows live pin, bit 1 follows latched pin.
// - four pin addresses; both pins low gives 1011100 plus R/W.
// - a generic address matches regardless of either select pin.
// - live pin sampled on every cycle with clk_en high; address tracks it without reset.
// - latched pin captured once 768 us after hardware reset release.
// - software reset write recaptures latched pin after same delay.
`timescale 1ns/10ps
`include "itas_regs.svh"
module itas_addr_select
  import itas_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // select pins
  input wire logic addr_select_live,
  input wire logic addr_select_latched,
  // from I2C register logic
  input wire logic soft_reset,
  input wire logic [6:0] rx_addr,
  input wire logic rx_addr_valid,
  // results
  output logic [6:0] target_addr,
  output logic addr_match,
  output logic generic_match,
  output logic addr_ready
);
  localparam logic [`ITAS_CNT_W-1:0] DELAY_CYC = `ITAS_CNT_W'(`ITAS_LATCH_DELAY_CYC);
  localparam logic [`ITAS_CNT_W-1:0] CNT_ONE = `ITAS_CNT_W'(1);
  localparam logic [`ITAS_CNT_W-1:0] CNT_LAST = DELAY_CYC - CNT_ONE;
  localparam logic [6:0] BASE_ADDR = `ITAS_ADDR_BASE;
  localparam logic [6:0] GENERIC_ADDR = `ITAS_GENERIC_ADDR;

  // synchronised pin levels
  itas_sync_if sync_bus ();

  // capture sequencer
  itas_state_t state_reg;
  itas_state_t state_next;

  // delay counter
  logic [`ITAS_CNT_W-1:0] cnt_reg;
  logic [`ITAS_CNT_W-1:0] cnt_next;
  logic count_done;

  // captured latched pin
  logic latched_reg;
  logic latched_next;
  logic capture_now;

  // address compare
  logic [6:0] addr_next;
  logic pin_hit;
  logic generic_hit;
  logic ready_next;

  // both pins pass two flops before any logic reads them
  itas_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pins({addr_select_latched, addr_select_live}),
    .sync(sync_bus.src)
  );

  // last cycle of the capture delay
  assign count_done = (cnt_reg == CNT_LAST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ITAS_WAIT: begin
        state_next = ITAS_COUNT;
      end
      ITAS_COUNT: begin
        if (count_done) begin
          state_next = ITAS_HOLD;
        end
      end
      ITAS_HOLD: begin
        state_next = ITAS_HOLD;
      end
      default: begin
        state_next = ITAS_WAIT;
      end
    endcase
    if (soft_reset) begin
      state_next = ITAS_COUNT;
    end
  end

  always_comb begin
    cnt_next = cnt_reg;
    if (soft_reset) begin
      cnt_next = '0;
    end else if (state_reg != ITAS_COUNT) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + CNT_ONE;
    end
  end

  assign capture_now = (state_reg == ITAS_COUNT) && count_done && !soft_reset;

  always_comb begin
    latched_next = latched_reg;
    if (capture_now) begin
      latched_next = sync_bus.latched;
    end
  end

  always_comb begin
    addr_next = BASE_ADDR;
    addr_next[`ITAS_LIVE_BIT] = sync_bus.live;
    addr_next[`ITAS_LATCHED_BIT] = latched_reg;
  end

  // compare against the next address so a match needs no extra cycle
  assign pin_hit = (rx_addr == addr_next);

  assign generic_hit = (rx_addr == GENERIC_ADDR);

  // soft reset drops ready at once
  assign ready_next = (state_reg == ITAS_HOLD) && !soft_reset;

  // sequencer state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ITAS_WAIT;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // delay count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
    end
  end

  // captured level, reads low until the first capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latched_reg <= 1'b0;
    end else if (clk_en) begin
      latched_reg <= latched_next;
    end
  end

  // target address output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      target_addr <= BASE_ADDR;
    end else if (clk_en) begin
      target_addr <= addr_next;
    end
  end

  // capture done flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_ready <= 1'b0;
    end else if (clk_en) begin
      addr_ready <= ready_next;
    end
  end

  // any address hit, pin or generic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_match <= 1'b0;
    end else if (clk_en) begin
      addr_match <= rx_addr_valid && (pin_hit || generic_hit);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      generic_match <= 1'b0;
    end else if (clk_en) begin
      generic_match <= rx_addr_valid && generic_hit;
    end
  end

endmodule : itas_addr_select

// >>> tb/itas_host_model.sv
// Purpose: host side model
// Assumes: one request at a time
// Notes: latched pin never moves
`timescale 1ns/10ps
module itas_host_model (
  // clock
  input wire logic clock,
  // device side
  output logic addr_select_live = 1'h0,
  output logic addr_select_latched = 1'h1,
  output logic [6:0] rx_addr = 7'h0,
  output logic rx_addr_valid = 1'h0
);
  task pin(input logic v);
    @(posedge clock) #1 addr_select_live = v;
  endtask : pin
  task send(input logic [6:0] a);
    @(posedge clock) #1 rx_addr = a;
    rx_addr_valid = 1'h1;
    @(posedge clock) #1 rx_addr_valid = 1'h0;
  endtask : send
endmodule : itas_host_model

// >>> tb/itas_chk.sv
// Purpose: port checks
// Assumes: host keeps pin rules
// Notes: bound at foot
`timescale 1ns/10ps
module itas_chk (
  // inputs
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic addr_select_live,
  input wire logic addr_select_latched,
  input wire logic soft_reset,
  input wire logic [6:0] rx_addr,
  input wire logic rx_addr_valid,
  // outputs
  input wire logic [6:0] target_addr,
  input wire logic addr_match,
  input wire logic generic_match,
  input wire logic addr_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_fixed_bits: assert property (target_addr[6:2] == 5'h17) else $error("bits");
  a_pin_match: assert property (rx_addr_valid && clk_en &&
    rx_addr == target_addr && $stable(target_addr) |=> addr_match) else $error("match");
  a_generic_hit: assert property (rx_addr_valid && clk_en &&
    rx_addr == 7'h5B |=> generic_match && addr_match) else $error("generic");
  a_live_track: assert property (($stable(addr_select_live) && clk_en &&
    $past(rst_n, 4))[*4] |-> target_addr[0] == addr_select_live) else $error("live");
  a_capture_hold: assert property (addr_ready && $past(addr_ready) |->
    $stable(target_addr[1])) else $error("hold");
  a_capture_val: assert property ($rose(addr_ready) |->
    target_addr[1] == addr_select_latched) else $error("capture");
  a_soft_drop: assert property (soft_reset && clk_en |=> !addr_ready[*8])
    else $error("soft");
  cover property ($rose(addr_ready));
  cover property (generic_match);
  cover property (addr_match && !generic_match);
endmodule : itas_chk
bind itas_addr_select itas_chk itas_chk_inst (.*);

// >>> tb/itas_tb_top.sv
// Purpose: bench
// Assumes: clk_en held high except while t_freeze drops it
// Notes: one capture after reset
`timescale 1ns/10ps
module i2c_target_address_select_tb_top;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic soft_reset = 1'h0;
  logic clk_en = 1'h1;
  logic addr_select_live, addr_select_latched, rx_addr_valid;
  logic addr_match, generic_match, addr_ready;
  logic [6:0] rx_addr, target_addr;
  int errors = 0;
  int compares = 0;
  initial begin
    forever #4 clock = ~clock;
  end
  itas_host_model itas_host_model_inst (.*);
  itas_addr_select itas_addr_select_inst (.*);
  task chk(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task t_capture;
    repeat (95000) @(posedge clock);
    #1 chk({6'h0, addr_ready}, 7'h0);
    repeat (1100) @(posedge clock);
    #1 chk({6'h0, addr_ready}, 7'h1);
    chk(target_addr, 7'h5E);
  endtask : t_capture
  task t_freeze;
    @(posedge clock) #1 clk_en = 1'h0;
    itas_host_model_inst.pin(1'h1);
    repeat (6) @(posedge clock);
    #1 chk(target_addr, 7'h5E);
    clk_en = 1'h1;
    repeat (4) @(posedge clock);
    #1 chk(target_addr, 7'h5F);
    itas_host_model_inst.pin(1'h0);
    repeat (4) @(posedge clock);
    #1 chk(target_addr, 7'h5E);
  endtask : t_freeze
  task t_live;
    for (int i = 1; i >= 0; i--) begin
      itas_host_model_inst.pin(i[0]);
      repeat (4) @(posedge clock);
      #1 chk(target_addr, {6'h2F, i[0]});
      itas_host_model_inst.send({6'h2F, i[0]});
      chk({5'h0, addr_match, generic_match}, 7'h2);
    end
    itas_host_model_inst.send(7'h5B);
    chk({5'h0, addr_match, generic_match}, 7'h3);
    itas_host_model_inst.send(7'h5C);
    chk({5'h0, addr_match, generic_match}, 7'h0);
  endtask : t_live
  task t_soft;
    @(posedge clock) #1 soft_reset = 1'h1;
    @(posedge clock) #1 soft_reset = 1'h0;
    chk({6'h0, addr_ready}, 7'h0);
  endtask : t_soft
  initial begin
    repeat (8) @(posedge clock);
    chk(target_addr, 7'h5C);
    #1 rst_n = 1'h1;
    t_capture();
    t_live();
    t_freeze();
    t_soft();
    print_verdict();
  end
  initial begin
    #800000;
    errors++;
    print_verdict();
  end
endmodule : i2c_target_address_select_tb_top
